//--- src/rims_pkg.sv
// rims_pkg: shared constants, carriers and decode helpers for the
// rfid interrupt mask and receive status register bank.
// assumes a 32-bit axi4-lite bus with one register per aligned word.
package rims_pkg;

    ////////////////////////////////////////////////////////////////////
    // register indices, byte address is four times the index
    localparam logic [5:0] IDX_CAUSE = 6'h0c;
    localparam logic [5:0] IDX_MASK = 6'h0d;
    localparam logic [5:0] IDX_GAIN = 6'h0e;
    localparam logic [5:0] IDX_RSSI = 6'h0f;

    // values after reset or while the chip enable is low
    localparam logic [7:0] MASK_RST = 8'h37;
    localparam logic [7:0] CAUSE_RST = 8'h00;

    // cause and mask bit positions
    localparam int BIT_TX_END = 7;
    localparam int BIT_RX_START = 6;
    localparam int BIT_FIFO = 5;
    localparam int BIT_CRC = 4;
    localparam int BIT_HEADER = 3;
    localparam int BIT_SHORT = 2;
    localparam int BIT_PREAMBLE = 1;
    localparam int BIT_NORESP = 0;

    // fifo level limits for the level interrupt
    localparam logic [4:0] FIFO_LOW = 5'h06;
    localparam logic [4:0] FIFO_HIGH = 5'h12;

    // axi response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////
    // receiver and transmitter events, same clock as the bank
    typedef struct packed {
        logic tx_start;
        logic tx_done;
        logic rx_start;
        logic rx_active;
        logic rx_done;
        logic rx_no_crc;
        logic crc_fail;
        logic header_err;
        logic preamble_err;
        logic no_resp;
    } rims_evt_t;

    // analog health flags, asynchronous to the bank
    typedef struct packed {
        logic rf_level_stable;
        logic pll_locked;
        logic osc_stable;
    } rims_health_t;

    // register write and read strobes from the bus slave
    typedef struct packed {
        logic en;
        logic [5:0] idx;
        logic [7:0] data;
    } rims_wr_t;

    typedef struct packed {
        logic en;
        logic [5:0] idx;
    } rims_rd_t;

    ////////////////////////////////////////////////////////////////////
    // byte address to register index
    function automatic logic [5:0] rims_idx(input logic [7:0] addr);
        return addr[7:2];
    endfunction : rims_idx

    // true for an index that holds a register
    function automatic logic rims_mapped(input logic [5:0] idx);
        return (idx >= IDX_CAUSE) && (idx <= IDX_RSSI);
    endfunction : rims_mapped

endpackage : rims_pkg

//--- src/rims_axil_slave.sv
// rims_axil_slave: axi4-lite slave turning bus transfers into
// one-cycle register strobes for the bank.
// assumes the bank answers read data in the cycle of the strobe.
`timescale 1ns/1ns
module rims_axil_slave #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // write address and data
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address and data
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // register strobes
    output rims_pkg::rims_wr_t reg_wr,
    output rims_pkg::rims_rd_t reg_rd,
    input wire logic [7:0] rd_data
);

    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_held;
        logic w_held;
        logic [5:0] widx;
        logic [7:0] wdata;
        logic wlane0;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } rims_axs_t;

    rims_axs_t q;
    rims_axs_t d;
    logic do_wr;
    logic [5:0] ridx;

    ////////////////////////////////////////////////////////////////////
    // strobes towards the bank
    assign do_wr = q.aw_held & q.w_held & ~q.bvalid;
    assign ridx = rims_pkg::rims_idx(s_axi_araddr[7:0]);
    assign reg_wr = '{en: do_wr & q.wlane0, idx: q.widx, data: q.wdata};
    assign reg_rd = '{en: s_axi_arvalid & q.arready, idx: ridx};

    // next state of both channels
    always_comb
    begin
        d = q;
        if (s_axi_awvalid && q.awready)
        begin
            d.awready = 1'b0;
            d.aw_held = 1'b1;
            d.widx = rims_pkg::rims_idx(s_axi_awaddr[7:0]);
        end
        if (s_axi_wvalid && q.wready)
        begin
            d.wready = 1'b0;
            d.w_held = 1'b1;
            d.wdata = s_axi_wdata[7:0];
            d.wlane0 = s_axi_wstrb[0];
        end
        if (do_wr)
        begin
            d.aw_held = 1'b0;
            d.w_held = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = rims_pkg::rims_mapped(q.widx) ?
                rims_pkg::RESP_OKAY : rims_pkg::RESP_SLVERR;
        end
        if (q.bvalid && s_axi_bready)
        begin
            d.bvalid = 1'b0;
            d.awready = 1'b1;
            d.wready = 1'b1;
        end
        if (reg_rd.en)
        begin
            d.arready = 1'b0;
            d.rvalid = 1'b1;
            if (rims_pkg::rims_mapped(ridx))
            begin
                d.rdata = {24'h000000, rd_data};
                d.rresp = rims_pkg::RESP_OKAY;
            end
            else
            begin
                d.rdata = 32'h00000000;
                d.rresp = rims_pkg::RESP_SLVERR;
            end
        end
        if (q.rvalid && s_axi_rready)
        begin
            d.rvalid = 1'b0;
            d.arready = 1'b1;
        end
    end

    // state register, ready high after reset
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            q <= '0;
            q.awready <= 1'b1;
            q.wready <= 1'b1;
            q.arready <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    // outputs straight from flops
    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;

endmodule : rims_axil_slave

//--- src/rims_regs.sv
// rims_regs: interrupt cause, interrupt mask, gain and health status
// and signal strength registers of the rfid reader, on axi4-lite.
// assumes receiver events come on core_clk; health flags and the
// chip enable pin are asynchronous and are synchronised here.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ns
module rims_regs #(
    parameter int ADDR_W = 8,
    parameter int LEN_W = 16
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // axi4-lite write address and data
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // chip enable pin
    input wire logic chip_en,
    // receiver and transmitter events
    input wire rims_pkg::rims_evt_t evt,
    input wire logic [4:0] fifo_level,
    input wire logic [LEN_W-1:0] rx_bit_cnt,
    input wire logic [LEN_W-1:0] rx_len_expect,
    // receiver status
    input wire logic [2:0] agc_level,
    input wire logic rx_chan_sel,
    input wire logic [3:0] rssi_i,
    input wire logic [3:0] rssi_q,
    // analog health flags
    input wire rims_pkg::rims_health_t health,
    // interrupt line
    output logic irq
);

    ////////////////////////////////////////////////////////////////////
    // whole state of the bank

    typedef struct packed {
        logic en_s1;
        logic en_s2;
        logic [2:0] hl_s1;
        logic [2:0] hl_s2;
        logic [7:0] mask;
        logic [7:0] cause;
        logic fifo_cond;
        logic sel;
        logic [3:0] str_q;
        logic [3:0] str_i;
        logic [2:0] agc;
        logic irq;
    } rims_state_t;

    rims_state_t q;
    rims_state_t d;

    rims_pkg::rims_wr_t reg_wr;
    rims_pkg::rims_rd_t reg_rd;
    logic [7:0] rd_data;

    logic fifo_hit;
    logic short_rx;
    logic [7:0] set_v;
    logic [7:0] clr_v;

    ////////////////////////////////////////////////////////////////////
    // bus slave

    rims_axil_slave #(
        .ADDR_W(ADDR_W)
    ) u_bus (
        .core_clk(core_clk),
        .rst(rst),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .rd_data(rd_data)
    );

    ////////////////////////////////////////////////////////////////////
    // event conditions

    // fifo level outside its comfort band
    assign fifo_hit = (fifo_level < rims_pkg::FIFO_LOW) ||
        (fifo_level > rims_pkg::FIFO_HIGH);

    // reception ended before the expected bit count
    assign short_rx = evt.rx_done && (rx_bit_cnt < rx_len_expect);

    // one set bit per event, same layout as the mask
    always_comb
    begin
        set_v = 8'h00;
        set_v[rims_pkg::BIT_TX_END] = evt.tx_done;
        set_v[rims_pkg::BIT_RX_START] = evt.rx_start;
        // rising edge of the level condition only
        set_v[rims_pkg::BIT_FIFO] = evt.rx_active & fifo_hit &
            ~q.fifo_cond;
        // no crc error when receiving without crc
        set_v[rims_pkg::BIT_CRC] = evt.crc_fail &
            ~evt.rx_no_crc;
        set_v[rims_pkg::BIT_HEADER] = evt.header_err;
        set_v[rims_pkg::BIT_SHORT] = short_rx;
        set_v[rims_pkg::BIT_PREAMBLE] = evt.preamble_err;
        set_v[rims_pkg::BIT_NORESP] = evt.no_resp;
    end

    // clear bits from a read of the cause register or a one written
    always_comb
    begin
        clr_v = 8'h00;
        if (reg_rd.en && (reg_rd.idx == rims_pkg::IDX_CAUSE))
        begin
            clr_v = 8'hff;
        end
        if (reg_wr.en && (reg_wr.idx == rims_pkg::IDX_CAUSE))
        begin
            clr_v = clr_v | reg_wr.data;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        d = q;

        // two-flop synchronisers for the pins
        d.en_s1 = chip_en;
        d.en_s2 = q.en_s1;
        d.hl_s1 = health;
        d.hl_s2 = q.hl_s1;

        // level condition tracked only while receiving
        d.fifo_cond = evt.rx_active & fifo_hit;

        // gain level sampled every cycle
        d.agc = agc_level;

        // sticky causes, a set beats a clear in the same cycle
        d.cause = (q.cause & ~clr_v) | set_v;

        // mask write from software
        if (reg_wr.en && (reg_wr.idx == rims_pkg::IDX_MASK))
        begin
            d.mask = reg_wr.data;
        end

        // channel and strengths follow the receiver while it runs
        if (evt.rx_active || evt.rx_start)
        begin
            d.sel = rx_chan_sel;
            d.str_q = rssi_q;
            d.str_i = rssi_i;
        end
        else if (evt.tx_start)
        begin
            // stale after a new transmission begins
            d.sel = 1'b0;
            d.str_q = 4'h0;
            d.str_i = 4'h0;
        end

        // chip disabled: presets hold
        if (!q.en_s2)
        begin
            d.mask = rims_pkg::MASK_RST;
            d.cause = rims_pkg::CAUSE_RST;
            d.fifo_cond = 1'b0;
        end

        // line follows the next flags and mask; tx-end and rx-start
        // have no mask bit of their own and always interrupt
        d.irq = |(d.cause & d.mask) | d.cause[rims_pkg::BIT_TX_END] |
            d.cause[rims_pkg::BIT_RX_START];
    end

    ////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            q <= '0;
            q.mask <= rims_pkg::MASK_RST;
            q.cause <= rims_pkg::CAUSE_RST;
        end
        else
        begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data mux

    always_comb
    begin
        rd_data = 8'h00;
        if (reg_rd.idx == rims_pkg::IDX_CAUSE)
        begin
            // value before the read clears it
            rd_data = q.cause;
        end
        else if (reg_rd.idx == rims_pkg::IDX_MASK)
        begin
            rd_data = q.mask;
        end
        else if (reg_rd.idx == rims_pkg::IDX_GAIN)
        begin
            // reserved top bit reads zero
            rd_data = {1'b0, q.agc, q.sel, q.hl_s2};
        end
        else if (reg_rd.idx == rims_pkg::IDX_RSSI)
        begin
            rd_data = {q.str_q, q.str_i};
        end
    end

    // interrupt line from its flop
    assign irq = q.irq;

endmodule : rims_regs

//--- verif/rims_regs_assertions.sv
// rims_regs_assertions: port-level checks of the register bank.
// assumes the ports of rims_regs and a single clock domain.
`timescale 1ns/1ns
module rims_regs_chk (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // read channel and write response
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // pins
    input wire logic chip_en,
    input wire logic irq
);
    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    // read request steps
    sequence rd_take_s;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence rd_bad_s;
        rd_take_s ##0 (s_axi_araddr[7:2] < 6'h0c
            || s_axi_araddr[7:2] > 6'h0f);
    endsequence
    sequence rd_gain_s;
        rd_take_s ##0 (s_axi_araddr == 8'h38);
    endsequence
    ////////////////////////////////////////
    read_answer_a: assert property (rd_take_s |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    rd_unmapped_a: assert property (rd_bad_s |=> s_axi_rresp == 2'h2
        && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
    gain_reserved_a: assert property (rd_gain_s |=> !s_axi_rdata[7])
        else $error("reserved gain bit set");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write resp moved");
    ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while answer pending");
    rdata_upper_a: assert property (s_axi_rvalid |-> !(|s_axi_rdata[31:8]))
        else $error("upper read data not zero");
    reset_quiet_a: assert property ($fell(rst) |-> !irq && !s_axi_bvalid
        && !s_axi_rvalid) else $error("outputs busy after reset");
    en_low_quiet_a: assert property (!chip_en [*5] |=> !irq)
        else $error("interrupt while chip disabled");
endmodule : rims_regs_chk

bind rims_regs rims_regs_chk chk_u (.core_clk(core_clk), .rst(rst),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .chip_en(chip_en), .irq(irq));

//--- verif/rims_host_model.sv
// rims_host_model: axi4-lite master standing in for the host.
// assumes a slave with registered readies; one transfer at a time.
`timescale 1ns/1ns
module rims_host_model (
    // clock
    input wire logic core_clk,
    // write side
    output logic [7:0] aw_a,
    output logic aw_v,
    input wire logic aw_r,
    output logic [31:0] w_d,
    output logic [3:0] w_s,
    output logic w_v,
    input wire logic w_r,
    input wire logic [1:0] b_p,
    input wire logic b_v,
    output logic b_r,
    // read side
    output logic [7:0] ar_a,
    output logic ar_v,
    input wire logic ar_r,
    input wire logic [31:0] r_d,
    input wire logic [1:0] r_p,
    input wire logic r_v,
    output logic r_rd
);
    // idle bus at time zero
    initial
    begin
        {aw_a, aw_v, w_d, w_v, b_r, ar_a, ar_v, r_rd} = '0;
        w_s = 4'hf;
    end
    // write: offer both channels, release each when taken
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d,
        output logic [1:0] r);
        logic aw_t, w_t, b_t, b_s;
        @(posedge core_clk);
        aw_a <= a;
        w_d <= d;
        aw_v <= 1'b1;
        w_v <= 1'b1;
        forever
        begin
            // settled handshakes seen before the sampling edge
            @(negedge core_clk);
            aw_t = aw_v && aw_r;
            w_t = w_v && w_r;
            b_t = b_v && b_r;
            b_s = b_v && !b_r;
            r = b_p;
            @(posedge core_clk);
            if (aw_t)
                aw_v <= 1'b0;
            if (w_t)
                w_v <= 1'b0;
            // bready a cycle after the answer shows, so it must stand
            if (b_s)
                b_r <= 1'b1;
            if (b_t)
            begin
                b_r <= 1'b0;
                break;
            end
        end
    endtask : bus_wr
    // read: hold request until taken, rready until answered
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        logic ar_t, r_t, r_s;
        @(posedge core_clk);
        ar_a <= a;
        ar_v <= 1'b1;
        forever
        begin
            @(negedge core_clk);
            ar_t = ar_v && ar_r;
            r_t = r_v && r_rd;
            r_s = r_v && !r_rd;
            d = r_d;
            r = r_p;
            @(posedge core_clk);
            if (ar_t)
                ar_v <= 1'b0;
            // rready a cycle after the answer shows, so it must stand
            if (r_s)
                r_rd <= 1'b1;
            if (r_t)
            begin
                r_rd <= 1'b0;
                break;
            end
        end
    endtask : bus_rd
endmodule : rims_host_model

//--- verif/rims_regs_bench.sv
// rims_regs_bench: self-checking bench of the rfid register bank.
// assumes the host model as bus master and events on core_clk.
`timescale 1ns/1ns
module rims_regs_bench;
    logic core_clk, rst, chip_en, irq, rx_chan_sel;
    rims_pkg::rims_evt_t evt;
    rims_pkg::rims_health_t health;
    logic [4:0] fifo_level;
    logic [15:0] rx_bit_cnt, rx_len_expect;
    logic [2:0] agc_level;
    logic [3:0] rssi_i, rssi_q, w_s;
    logic [7:0] aw_a, ar_a, ev;
    logic [31:0] w_d, r_d;
    logic [1:0] b_p, r_p;
    logic aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_rd;
    int failures, checked;
    ////////////////////////////////////////
    rims_regs dut_u (.core_clk(core_clk), .rst(rst), .s_axi_awaddr(aw_a),
        .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(w_d),
        .s_axi_wstrb(w_s), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
        .s_axi_bresp(b_p), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
        .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
        .s_axi_rdata(r_d), .s_axi_rresp(r_p), .s_axi_rvalid(r_v),
        .s_axi_rready(r_rd), .chip_en(chip_en), .evt(evt),
        .fifo_level(fifo_level), .rx_bit_cnt(rx_bit_cnt),
        .rx_len_expect(rx_len_expect), .agc_level(agc_level),
        .rx_chan_sel(rx_chan_sel), .rssi_i(rssi_i), .rssi_q(rssi_q),
        .health(health), .irq(irq));
    rims_host_model host_u (.core_clk(core_clk), .aw_a(aw_a), .aw_v(aw_v),
        .aw_r(aw_r), .w_d(w_d), .w_s(w_s), .w_v(w_v), .w_r(w_r), .b_p(b_p),
        .b_v(b_v), .b_r(b_r), .ar_a(ar_a), .ar_v(ar_v), .ar_r(ar_r),
        .r_d(r_d), .r_p(r_p), .r_v(r_v), .r_rd(r_rd));
    // 25 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    ////////////////////////////////////////
    // expected response from the address map
    function automatic logic [1:0] exp_resp(input logic [7:0] a);
        return (a[7:2] >= 6'h0c && a[7:2] <= 6'h0f) ? 2'h0 : 2'h2;
    endfunction : exp_resp
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [1:0] r;
        host_u.bus_wr(a, {24'h0, d}, r);
        chk("bresp", {30'h0, exp_resp(a)}, {30'h0, r});
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e,
        input string n);
        logic [31:0] d;
        logic [1:0] r;
        host_u.bus_rd(a, d, r);
        chk(n, {24'h0, e}, d);
        chk("rresp", {30'h0, exp_resp(a)}, {30'h0, r});
    endtask : rd
    // one-cycle event pulse, level inputs kept
    task automatic pulse(input int b);
        @(posedge core_clk);
        case (b)
        7: evt.tx_done <= 1'b1;
        6: evt.rx_start <= 1'b1;
        5: fifo_level <= 5'h03;
        4: evt.crc_fail <= 1'b1;
        3: evt.header_err <= 1'b1;
        2: evt.rx_done <= 1'b1;
        1: evt.preamble_err <= 1'b1;
        default: evt.no_resp <= 1'b1;
        endcase
        @(posedge core_clk);
        evt <= evt & 10'h050;
        repeat (2) @(posedge core_clk);
    endtask : pulse
    task automatic tally_and_finish();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish
    // watchdog against a hung handshake
    initial
    begin
        #400000;
        failures++;
        tally_and_finish();
    end
    ////////////////////////////////////////
    // main sequence
    initial
    begin
        {rst, chip_en, evt, fifo_level} = {1'b1, 1'b1, 10'h0, 5'h0a};
        {rx_bit_cnt, rx_len_expect} = {16'h5, 16'h8};
        {agc_level, rx_chan_sel, rssi_i, rssi_q, health} = '0;
        void'($urandom(79));
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        repeat (4) @(posedge core_clk);
        rd(8'h34, 8'h37, "mask reset");
        rd(8'h30, 8'h00, "cause reset");
        $display("test reset done");
        // each event alone under its own mask bit
        for (int b = 0; b < 8; b++)
        begin
            wr(8'h34, 8'h01 << b);
            evt.rx_active <= (b == 5);
            pulse(b);
            #1 chk("irq set", 1, irq);
            rd(8'h30, 8'h01 << b, "cause");
            #1 chk("irq clear", 0, irq);
            evt.rx_active <= 1'b0;
            fifo_level <= 5'h0a;
        end
        $display("test events done");
        // masked event, then unmask and one-to-clear
        wr(8'h34, 8'h00);
        pulse(0);
        #1 chk("irq masked", 0, irq);
        wr(8'h34, 8'h01);
        repeat (2) @(posedge core_clk);
        #1 chk("irq unmasked", 1, irq);
        wr(8'h30, 8'h01);
        #1 chk("irq w1c", 0, irq);
        // tx-end has no mask bit and interrupts anyway
        pulse(7);
        #1 chk("irq tx always", 1, irq);
        rd(8'h30, 8'h80, "cause tx");
        // crc failure without crc, full length stream
        evt.rx_no_crc <= 1'b1;
        pulse(4);
        evt.rx_no_crc <= 1'b0;
        rx_bit_cnt <= 16'h8;
        pulse(2);
        rd(8'h30, 8'h00, "no crc or short");
        // fifo limits: 6 and 18 stay quiet, 19 fires
        evt.rx_active <= 1'b1;
        foreach (ev[i])
        begin
            @(posedge core_clk);
            fifo_level <= (i == 7) ? 5'h06 : (i == 6) ? 5'h12 : 5'h0a;
        end
        rd(8'h30, 8'h00, "fifo at limits");
        @(posedge core_clk);
        fifo_level <= 5'h13;
        repeat (3) @(posedge core_clk);
        rd(8'h30, 8'h20, "fifo above");
        evt.rx_active <= 1'b0;
        $display("test refusals done");
        // random status during reception, held after it
        repeat (4)
        begin
            @(posedge core_clk);
            {agc_level, rx_chan_sel, rssi_i, rssi_q} <= 12'($urandom);
            health <= 3'($urandom);
            evt.rx_active <= 1'b1;
            repeat (3) @(posedge core_clk);
            ev = {rssi_q, rssi_i};
            evt.rx_active <= 1'b0;
            @(posedge core_clk);
            {rx_chan_sel, rssi_i, rssi_q} <= ~{rx_chan_sel, rssi_i, rssi_q};
            repeat (3) @(posedge core_clk);
            rd(8'h38, {1'b0, agc_level, ~rx_chan_sel, health},
                "gain");
            rd(8'h3c, ev, "strength");
        end
        // a new transmission makes the receive status stale
        @(posedge core_clk);
        evt.tx_start <= 1'b1;
        @(posedge core_clk);
        evt.tx_start <= 1'b0;
        rd(8'h3c, 8'h00, "strength tx");
        rd(8'h38, {1'b0, agc_level, 1'b0, health}, "gain tx");
        $display("test status done");
        // random mask values and unmapped places
        repeat (6)
        begin
            ev = 8'($urandom);
            wr(8'h34, ev);
            rd(8'h34, ev, "mask");
            rd(8'($urandom) & 8'h2c, 8'h00, "unmapped");
        end
        wr(8'h40, 8'h5a);
        // chip enable low presets the mask
        @(posedge core_clk);
        chip_en <= 1'b0;
        repeat (6) @(posedge core_clk);
        chip_en <= 1'b1;
        repeat (4) @(posedge core_clk);
        rd(8'h34, 8'h37, "mask after disable");
        $display("test registers done");
        tally_and_finish();
    end
endmodule : rims_regs_bench
